// ===== logic/mode_seq_defs.svh
`ifndef MODE_SEQ_DEFS_SVH
`define MODE_SEQ_DEFS_SVH

// Clock rate of the internal oscillator in MHz.
`define CLK_MHZ 20
// Startup and soft-start delays in ms.
`define STARTUP_DELAY_MS 10
`define SOFTSTART_DELAY_MS 10
// Least switch pulse width in ns.
`define MIN_PULSE_NS 25
// Switching rates in kHz.
`define RATE_SLOW_KHZ 1000
`define RATE_FAST_KHZ 2000

// Control field reset values.
`define STBY_EXIT_RESET 1'h0
`define BOOST_EN_RESET 1'h0
`define RATE_SEL_RESET 1'h0
`define VOUT_RESET 4'h7

// Bit positions of the synchronised pin group.
`define PIN_EXT_RESET_N 0
`define PIN_SUPPLY_LOW 1
`define PIN_THERMAL 2

`endif

// ===== logic/mode_seq_pkg.sv
package mode_seq_pkg;

  typedef enum logic [2:0] {
    MODE_RESET,
    MODE_STANDBY,
    MODE_STARTUP,
    MODE_BOOST_START,
    MODE_NORMAL
  } mode_type;

  typedef struct packed {
    logic standby_exit_bit;
    logic boost_en;
    logic switch_rate_select;
    logic [3:0] boost_output_voltage;
  } ctrl_type;

  typedef struct packed {
    logic thermal_shutdown;
    logic second_supply_low;
    logic external_reset_n;
  } pins_type;

endpackage : mode_seq_pkg

// ===== logic/mode_sequencer_boost_ctrl.sv
`timescale 1ns/1ps
`include "mode_seq_defs.svh"

module mode_sequencer_boost_ctrl
  import mode_seq_pkg::*;
#(
  parameter int STARTUP_CYC = `STARTUP_DELAY_MS * `CLK_MHZ * 1000,
  parameter int SOFTSTART_CYC = `SOFTSTART_DELAY_MS * `CLK_MHZ * 1000,
  parameter int PWM_W = 5
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire pins_type pins,
  input wire logic reg_wr,
  input wire ctrl_type reg_wr_mask,
  input wire ctrl_type reg_wr_data,
  input wire logic [PWM_W-1:0] pwm_width_req,
  output ctrl_type ctrl_rd,
  output mode_type mode_rd,
  output logic ref_enable,
  output logic chip_active,
  output logic boost_standby,
  output logic boost_soft_start,
  output logic switch_rate_select,
  output logic [3:0] boost_output_voltage,
  output logic switch_gate
);

  localparam int CNT_W = $clog2((STARTUP_CYC > SOFTSTART_CYC ? STARTUP_CYC : SOFTSTART_CYC) + 1);
  localparam int MIN_RAW = (`MIN_PULSE_NS * `CLK_MHZ + 999) / 1000;
  localparam logic [PWM_W-1:0] MIN_PULSE_CYC = PWM_W'(MIN_RAW < 1 ? 1 : MIN_RAW);
  localparam logic [PWM_W-1:0] PERIOD_SLOW = PWM_W'(`CLK_MHZ * 1000 / `RATE_SLOW_KHZ);
  localparam logic [PWM_W-1:0] PERIOD_FAST = PWM_W'(`CLK_MHZ * 1000 / `RATE_FAST_KHZ);
  localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(STARTUP_CYC - 1);
  localparam logic [CNT_W-1:0] SOFTSTART_LAST = CNT_W'(SOFTSTART_CYC - 1);
  localparam ctrl_type CTRL_DEFAULT = '{`STBY_EXIT_RESET, `BOOST_EN_RESET,
                                        `RATE_SEL_RESET, `VOUT_RESET};

  // Reset release through two flip-flops; assertion stays asynchronous.
  logic [1:0] rst_sync_ff;
  logic sys_rst_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
  end

  assign sys_rst_n = rst_sync_ff[1];

  // Pin synchronisers; only the second stage is read by logic.
  pins_type sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  logic reset_req;
  logic thermal;

  always_comb begin
    nxt_sync1 = sync1_ff;
    nxt_sync2 = sync2_ff;
    if (clk_en) begin
      nxt_sync1 = pins;
      nxt_sync2 = sync1_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  assign reset_req = !sync2_ff[`PIN_EXT_RESET_N] || sync2_ff[`PIN_SUPPLY_LOW];
  assign thermal = sync2_ff[`PIN_THERMAL];

  // Control register group.
  mode_type mode_ff, nxt_mode;
  ctrl_type ctrl_ff, nxt_ctrl;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (clk_en) begin
      if (reset_req || mode_ff == MODE_RESET) begin
        nxt_ctrl = CTRL_DEFAULT;
      end else if (reg_wr) begin
        nxt_ctrl = ctrl_type'((ctrl_ff & ~reg_wr_mask) | (reg_wr_data & reg_wr_mask));
      end
    end
  end

  always_ff @(posedge ref_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      ctrl_ff <= CTRL_DEFAULT;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Mode machine with its delay counter and converter run flag.
  logic [CNT_W-1:0] delay_cnt_ff, nxt_delay_cnt;
  logic boost_run_ff, nxt_boost_run;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_delay_cnt = delay_cnt_ff;
    nxt_boost_run = boost_run_ff;
    if (clk_en) begin
      nxt_delay_cnt = delay_cnt_ff + CNT_W'(1);
      if (reset_req) begin
        nxt_mode = MODE_RESET;
        nxt_delay_cnt = '0;
        nxt_boost_run = 1'h0;
      end else begin
        case (mode_ff)
          MODE_RESET: begin
            nxt_mode = MODE_STANDBY;
            nxt_delay_cnt = '0;
          end
          MODE_STANDBY: begin
            nxt_delay_cnt = '0;
            nxt_boost_run = 1'h0;
            if (ctrl_ff.standby_exit_bit) begin
              nxt_mode = MODE_STARTUP;
            end
          end
          MODE_STARTUP: begin
            if (!ctrl_ff.standby_exit_bit) begin
              nxt_mode = MODE_STANDBY;
              nxt_delay_cnt = '0;
            end else if (thermal) begin
              nxt_delay_cnt = '0;
            end else if (delay_cnt_ff == STARTUP_LAST) begin
              nxt_delay_cnt = '0;
              nxt_mode = ctrl_ff.boost_en ? MODE_BOOST_START : MODE_NORMAL;
            end
          end
          MODE_BOOST_START: begin
            if (!ctrl_ff.standby_exit_bit) begin
              nxt_mode = MODE_STANDBY;
              nxt_delay_cnt = '0;
            end else if (thermal) begin
              nxt_mode = MODE_STARTUP;
              nxt_delay_cnt = '0;
            end else if (!ctrl_ff.boost_en) begin
              nxt_mode = MODE_NORMAL;
              nxt_delay_cnt = '0;
            end else if (delay_cnt_ff == SOFTSTART_LAST) begin
              nxt_mode = MODE_NORMAL;
              nxt_delay_cnt = '0;
              nxt_boost_run = 1'h1;
            end
          end
          MODE_NORMAL: begin
            nxt_delay_cnt = '0;
            if (!ctrl_ff.boost_en) begin
              nxt_boost_run = 1'h0;
            end
            if (!ctrl_ff.standby_exit_bit) begin
              nxt_mode = MODE_STANDBY;
            end else if (thermal) begin
              nxt_mode = MODE_STARTUP;
              nxt_boost_run = 1'h0;
            end else if (ctrl_ff.boost_en && !boost_run_ff) begin
              nxt_mode = MODE_BOOST_START;
            end
          end
          default: begin
            nxt_mode = MODE_RESET;
            nxt_delay_cnt = '0;
            nxt_boost_run = 1'h0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      mode_ff <= MODE_RESET;
      delay_cnt_ff <= '0;
      boost_run_ff <= 1'h0;
    end else begin
      mode_ff <= nxt_mode;
      delay_cnt_ff <= nxt_delay_cnt;
      boost_run_ff <= nxt_boost_run;
    end
  end

  // Outputs decode the state flip-flops; fields reach the converter only after startup.
  logic conv_on;
  logic running;

  assign running = mode_ff == MODE_BOOST_START || mode_ff == MODE_NORMAL;
  assign conv_on = mode_ff == MODE_BOOST_START || (mode_ff == MODE_NORMAL && boost_run_ff);
  assign ctrl_rd = ctrl_ff;
  assign mode_rd = mode_ff;
  assign ref_enable = mode_ff != MODE_RESET && mode_ff != MODE_STANDBY;
  assign chip_active = running;
  assign boost_standby = !conv_on;
  assign boost_soft_start = mode_ff == MODE_BOOST_START;
  assign switch_rate_select = running ? ctrl_ff.switch_rate_select : `RATE_SEL_RESET;
  assign boost_output_voltage = running ? ctrl_ff.boost_output_voltage : `VOUT_RESET;

  // Switch pulse generator; the width is clamped so no period ever goes without a pulse.
  logic [PWM_W-1:0] pwm_cnt_ff, nxt_pwm_cnt;
  logic gate_ff, nxt_gate;
  logic [PWM_W-1:0] period;
  logic [PWM_W-1:0] width;

  always_comb begin
    period = switch_rate_select ? PERIOD_FAST : PERIOD_SLOW;
    width = pwm_width_req;
    if (width < MIN_PULSE_CYC) begin
      width = MIN_PULSE_CYC;
    end
    if (width > period - PWM_W'(1)) begin
      width = period - PWM_W'(1);
    end
    nxt_pwm_cnt = pwm_cnt_ff;
    nxt_gate = gate_ff;
    if (clk_en) begin
      if (!conv_on || pwm_cnt_ff >= period - PWM_W'(1)) begin
        nxt_pwm_cnt = '0;
      end else begin
        nxt_pwm_cnt = pwm_cnt_ff + PWM_W'(1);
      end
      nxt_gate = conv_on && pwm_cnt_ff < width;
    end
  end

  always_ff @(posedge ref_clk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      pwm_cnt_ff <= '0;
      gate_ff <= 1'h0;
    end else begin
      pwm_cnt_ff <= nxt_pwm_cnt;
      gate_ff <= nxt_gate;
    end
  end

  assign switch_gate = gate_ff;

  reset_forces_mode_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    (reset_req && clk_en) |=> mode_ff == MODE_RESET) else $error("reset not entered");

  defaults_in_reset_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    mode_ff == MODE_RESET |-> ctrl_ff == CTRL_DEFAULT) else $error("control not default");

  leave_reset_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    (mode_ff == MODE_RESET && !reset_req && clk_en) |=> mode_ff == MODE_STANDBY)
    else $error("reset release did not reach standby");

  exit_bit_low_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    (mode_ff == MODE_RESET && !reg_wr) ##1 (mode_ff == MODE_STANDBY) |-> !ctrl_ff.standby_exit_bit)
    else $error("exit bit high after reset");

  standby_quiet_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    mode_ff == MODE_STANDBY |-> !ref_enable && boost_standby && !chip_active)
    else $error("blocks active in standby");

  startup_delay_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    (mode_ff == MODE_STARTUP ##1 (mode_ff == MODE_NORMAL || mode_ff == MODE_BOOST_START))
    |-> $past(delay_cnt_ff) == STARTUP_LAST) else $error("startup delay wrong");

  thermal_hold_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    (thermal && clk_en && !reset_req && ctrl_ff.standby_exit_bit && running)
    |=> mode_ff == MODE_STARTUP && delay_cnt_ff == '0) else $error("thermal not held");

  boost_entry_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    (mode_ff == MODE_STARTUP && clk_en && !reset_req && !thermal && ctrl_ff.standby_exit_bit
     && ctrl_ff.boost_en && delay_cnt_ff == STARTUP_LAST) |=> mode_ff == MODE_BOOST_START)
    else $error("boost start not entered");

  softstart_len_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    (mode_ff == MODE_BOOST_START ##1 (mode_ff == MODE_NORMAL && boost_run_ff))
    |-> $past(delay_cnt_ff) == SOFTSTART_LAST) else $error("soft-start length wrong");

  boost_off_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    (mode_ff == MODE_NORMAL && !ctrl_ff.boost_en && clk_en) ##1 clk_en
    |-> (boost_standby || mode_ff != MODE_NORMAL)
    ##1 (!switch_gate || mode_ff != MODE_NORMAL)) else $error("converter not idle");

  apply_fields_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    running |-> boost_output_voltage == ctrl_ff.boost_output_voltage
    && switch_rate_select == ctrl_ff.switch_rate_select) else $error("fields not applied");

  no_skip_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    (conv_on && clk_en && pwm_cnt_ff == '0) |=> switch_gate) else $error("pulse skipped");

  rate_period_a: assert property (@(posedge ref_clk) disable iff (!sys_rst_n)
    pwm_cnt_ff <= period - PWM_W'(1) || $changed(switch_rate_select) || !$past(clk_en))
    else $error("period overrun");

endmodule : mode_sequencer_boost_ctrl

// ===== verif/host_model.sv
`timescale 1ns/1ps
module host_model
  import mode_seq_pkg::*;
(
  input wire logic ref_clk,
  output ctrl_type reg_wr_mask,
  output ctrl_type reg_wr_data,
  output logic reg_wr
);
  initial begin
    reg_wr = 1'h0;
    reg_wr_mask = '0;
    reg_wr_data = '0;
  end
  // After the taking edge the fields turn to their inverse, so a late sample cannot pass.
  task automatic write(input logic [6:0] mask, input logic [6:0] data);
    @(posedge ref_clk);
    #1;
    reg_wr = 1'h1;
    reg_wr_mask = mask;
    reg_wr_data = data;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'h0;
    reg_wr_mask = ~mask;
    reg_wr_data = ~data;
  endtask : write
endmodule : host_model

// ===== verif/mode_sequencer_boost_ctrl_tb.sv
`timescale 1ns/1ps
module mode_sequencer_boost_ctrl_tb;
  import mode_seq_pkg::*;
  // Short delays keep the run brief; every mode-duration count below derives from this value.
  localparam int SCYC = 20;
  logic ref_clk = 1'h0;
  logic rst_n;
  logic clk_en;
  pins_type pins;
  logic [4:0] pwm_width_req;
  logic reg_wr;
  ctrl_type reg_wr_mask;
  ctrl_type reg_wr_data;
  ctrl_type ctrl_rd;
  mode_type mode_rd;
  logic ref_enable;
  logic chip_active;
  logic boost_standby;
  logic boost_soft_start;
  logic switch_rate_select;
  logic [3:0] boost_output_voltage;
  logic switch_gate;
  int mismatches;
  int n_compared;
  int n;

  always #25 ref_clk = ~ref_clk;

  host_model i_host_model (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_wr_mask(reg_wr_mask),
    .reg_wr_data(reg_wr_data));

  mode_sequencer_boost_ctrl #(.STARTUP_CYC(SCYC), .SOFTSTART_CYC(SCYC), .PWM_W(5))
  i_mode_sequencer_boost_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .pins(pins), .reg_wr(reg_wr), .reg_wr_mask(reg_wr_mask), .reg_wr_data(reg_wr_data),
    .pwm_width_req(pwm_width_req), .ctrl_rd(ctrl_rd), .mode_rd(mode_rd),
    .ref_enable(ref_enable), .chip_active(chip_active), .boost_standby(boost_standby),
    .boost_soft_start(boost_soft_start), .switch_rate_select(switch_rate_select),
    .boost_output_voltage(boost_output_voltage), .switch_gate(switch_gate));

  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : chk

  task automatic chk_range(input string name, input int exp, input int got);
    n_compared++;
    if (got != exp) begin
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
      mismatches++;
    end
  endtask : chk_range

  // A mode that never arrives ends the run at once rather than hanging.
  task automatic wait_mode(input mode_type m, input int lim);
    for (int i = 0; i < lim && mode_rd !== m; i++) step(1);
    chk("mode_rd", m, mode_rd);
    if (mode_rd !== m) finish_test();
  endtask : wait_mode

  task automatic count_mode(input mode_type m, output int k);
    k = 0;
    while (mode_rd === m && k < 300) begin
      step(1);
      k++;
    end
  endtask : count_mode

  task automatic gate_high(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin
      step(1);
      if (switch_gate === 1'h1) k++;
    end
  endtask : gate_high

  task automatic t_defaults();
    wait_mode(MODE_STANDBY, 20);
    chk("ctrl_rd", 8'h07, ctrl_rd);
    chk("ref_enable", 8'h00, ref_enable);
    chk("boost_standby", 8'h01, boost_standby);
    chk("switch_gate", 8'h00, switch_gate);
  endtask : t_defaults

  task automatic t_startup();
    i_host_model.write(7'h3f, 7'h3f);
    step(1);
    chk("ctrl_rd", 8'h3f, ctrl_rd);
    chk("mode_rd", MODE_STANDBY, mode_rd);
    chk("switch_rate_select", 8'h00, switch_rate_select);
    i_host_model.write(7'h40, 7'h40);
    wait_mode(MODE_STARTUP, 5);
    count_mode(MODE_STARTUP, n);
    chk_range("startup_cycles", SCYC, n);
    chk("mode_rd", MODE_BOOST_START, mode_rd);
    chk("boost_soft_start", 8'h01, boost_soft_start);
    count_mode(MODE_BOOST_START, n);
    chk_range("soft_start_cycles", SCYC, n);
    chk("mode_rd", MODE_NORMAL, mode_rd);
    chk("boost_soft_start", 8'h00, boost_soft_start);
    chk("boost_standby", 8'h00, boost_standby);
    chk("switch_rate_select", 8'h01, switch_rate_select);
    chk("boost_output_voltage", 8'h0f, boost_output_voltage);
  endtask : t_startup

  task automatic t_pwm();
    pwm_width_req = 5'h03;
    step(12);
    gate_high(20, n);
    chk("gate_high_fast", 8'h06, n[7:0]);
    pwm_width_req = 5'h00;
    step(12);
    gate_high(20, n);
    chk("gate_high_min", 8'h02, n[7:0]);
    i_host_model.write(7'h1f, 7'h08);
    step(1);
    chk("switch_rate_select", 8'h00, switch_rate_select);
    chk("boost_output_voltage", 8'h08, boost_output_voltage);
    pwm_width_req = 5'h1f;
    step(22);
    gate_high(40, n);
    chk("gate_high_slow", 8'h26, n[7:0]);
  endtask : t_pwm

  task automatic t_boost_standby();
    i_host_model.write(7'h20, 7'h00);
    step(1);
    chk("boost_standby", 8'h01, boost_standby);
    chk("chip_active", 8'h01, chip_active);
    chk("mode_rd", MODE_NORMAL, mode_rd);
    gate_high(20, n);
    chk("gate_high_off", 8'h00, n[7:0]);
    i_host_model.write(7'h20, 7'h20);
    wait_mode(MODE_BOOST_START, 5);
    // A low clock enable must freeze the soft-start count.
    clk_en = 1'h0;
    step(30);
    chk("mode_rd", MODE_BOOST_START, mode_rd);
    clk_en = 1'h1;
    count_mode(MODE_BOOST_START, n);
    chk_range("soft_start_again", SCYC, n);
  endtask : t_boost_standby

  task automatic t_thermal();
    pins.thermal_shutdown = 1'h1;
    wait_mode(MODE_STARTUP, 6);
    step(3 * SCYC);
    chk("mode_rd", MODE_STARTUP, mode_rd);
    chk("chip_active", 8'h00, chip_active);
    chk("ref_enable", 8'h01, ref_enable);
    pins.thermal_shutdown = 1'h0;
    count_mode(MODE_STARTUP, n);
    chk_range("resume_cycles", SCYC + 2, n);
    chk("mode_rd", MODE_BOOST_START, mode_rd);
    i_host_model.write(7'h40, 7'h00);
    wait_mode(MODE_STANDBY, 5);
    chk("boost_standby", 8'h01, boost_standby);
  endtask : t_thermal

  task automatic t_reset_pins();
    pins.external_reset_n = 1'h0;
    wait_mode(MODE_RESET, 6);
    step(1);
    chk("ctrl_rd", 8'h07, ctrl_rd);
    i_host_model.write(7'h7f, 7'h7f);
    step(1);
    chk("ctrl_rd", 8'h07, ctrl_rd);
    pins.external_reset_n = 1'h1;
    wait_mode(MODE_STANDBY, 10);
    pins.second_supply_low = 1'h1;
    wait_mode(MODE_RESET, 6);
    pins.second_supply_low = 1'h0;
    wait_mode(MODE_STANDBY, 10);
    chk("ctrl_rd", 8'h07, ctrl_rd);
  endtask : t_reset_pins

  initial begin
    mismatches = 0;
    n_compared = 0;
    rst_n = 1'h0;
    clk_en = 1'h1;
    pins = 3'h1;
    pwm_width_req = 5'h03;
    step(2);
    rst_n = 1'h1;
    t_defaults();
    t_startup();
    t_pwm();
    t_boost_standby();
    t_thermal();
    t_reset_pins();
    finish_test();
  end
endmodule : mode_sequencer_boost_ctrl_tb
